/* logic/tgc_pkg.sv */
// package: offsets, fields, reset values and state codes of the gate control block
`default_nettype none
package tgc_pkg;
    // ======================================
    // register byte addresses
    localparam logic [7:0] OFF_GATE_CTRL = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
    // ======================================
    // gate control register fields
    localparam int BIT_GE = 7;
    localparam int BIT_POL = 6;
    localparam int BIT_TM = 5;
    localparam int BIT_SPM = 4;
    localparam int BIT_GO = 3;
    localparam int BIT_VAL = 2;
    localparam int BIT_SS_HI = 1;
    localparam int BIT_SS_LO = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_WMASK = 8'hF3;
    // ======================================
    // gate source codes
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_OVF = 2'h1;
    localparam logic [1:0] SRC_MATCH = 2'h2;
    localparam logic [1:0] SRC_WDT = 2'h3;
    // ======================================
    // interrupt status fields
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_EDGE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    // ======================================
    // single-pulse states
    typedef enum logic [1:0] {
        SP_IDLE = 2'b00,
        SP_ARMED = 2'b01,
        SP_PULSE = 2'b10
    } tgc_sp_t;
endpackage : tgc_pkg
`default_nettype wire

/* logic/tgc_gate_ctrl.sv */
// module: timer gate control with apb registers and interrupt
`default_nettype none
module tgc_gate_ctrl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic timer_on,
    input wire logic gate_pin,
    input wire logic other_overflow,
    input wire logic period_match,
    input wire logic watchdog_scaler,
    output logic count_enable,
    output logic irq
);
    // ======================================
    // register map, one 32-bit word each, unused upper bits read zero
    //   0x00 gate control
    //        7 gate enable, 6 polarity (1 = active high), 5 toggle mode,
    //        4 single-pulse mode, 3 go/done (write 1 with bit 4 to arm),
    //        2 current gate value (read only), 1:0 gate source
    //   0x04 interrupt status, write one to clear
    //        0 single pulse done, 1 processed gate opened
    //   0x08 interrupt mask, same layout as status
    // bus has no wait states; read data is captured in the setup cycle
    // count enable and gate value trail their sources by one clock; the toggle flop and a single-pulse start each add one more
    // limits worth knowing
    //   a gate already active when the pulse is armed waits for the next edge
    //   clearing single-pulse mode in the clock a pulse ends still posts the done status
    //   a new interrupt event wins over a write-one-to-clear in the same clock
    //   sources are taken as synchronous; async pins need a synchroniser upstream
    // ======================================
    // state
    logic [7:0] ctl_q, ctl_d;
    logic [tgc_pkg::IRQ_W-1:0] ist_q, ist_d, imsk_q, imsk_d;
    logic tff_q, tff_d, act_prev_q, act_prev_d, gtd_prev_q, gtd_prev_d;
    logic gval_q, gval_d, cen_q, cen_d;
    logic [31:0] rd_q, rd_d;
    tgc_pkg::tgc_sp_t sp_q, sp_d;
    logic src_raw, act, gated, proc, go;
    logic setup, wr, wr_ctl, wr_ist, wr_imsk, hit, done_ev, edge_ev;
    logic primed_q, primed_d, plain_hi;

    // address decode shared by read and write paths
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == tgc_pkg::OFF_GATE_CTRL) || (a == tgc_pkg::OFF_IRQ_STAT)
            || (a == tgc_pkg::OFF_IRQ_MASK);
    endfunction

    // ======================================
    // apb strobes
    assign setup = psel & ~penable;
    assign wr = psel & penable & pwrite & mapped(paddr);
    assign wr_ctl = wr & (paddr == tgc_pkg::OFF_GATE_CTRL);
    assign wr_ist = wr & (paddr == tgc_pkg::OFF_IRQ_STAT);
    assign wr_imsk = wr & (paddr == tgc_pkg::OFF_IRQ_MASK);
    assign hit = mapped(paddr);
    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;
    assign prdata = rd_q;

    // ======================================
    // gate path
    always_comb begin
        unique case (ctl_q[tgc_pkg::BIT_SS_HI:tgc_pkg::BIT_SS_LO])
            tgc_pkg::SRC_PIN: src_raw = gate_pin;
            tgc_pkg::SRC_OVF: src_raw = other_overflow;
            tgc_pkg::SRC_MATCH: src_raw = period_match;
            tgc_pkg::SRC_WDT: src_raw = watchdog_scaler;
        endcase
        act = ctl_q[tgc_pkg::BIT_POL] ? src_raw : ~src_raw;
        gated = ctl_q[tgc_pkg::BIT_TM] ? tff_q : act;
        // pulse logic only steers the gate in single-pulse mode
        if (ctl_q[tgc_pkg::BIT_SPM]) begin
            proc = (sp_q == tgc_pkg::SP_PULSE) & gated;
        end else begin
            proc = gated;
        end
    end
    assign go = (sp_q != tgc_pkg::SP_IDLE);
    // plain active-high path, used by the routing checks
    assign plain_hi = ctl_q[tgc_pkg::BIT_POL] & ~ctl_q[tgc_pkg::BIT_TM]
        & ~ctl_q[tgc_pkg::BIT_SPM];

    // next values of gate flops and count enable
    always_comb begin
        act_prev_d = act;
        gtd_prev_d = gated;
        primed_d = 1'b1; // edge status live from the second clock
        // toggle flop held clear outside toggle mode
        if (!ctl_q[tgc_pkg::BIT_TM]) begin
            tff_d = 1'b0;
        end else if (act & ~act_prev_q) begin
            tff_d = ~tff_q;
        end else begin
            tff_d = tff_q;
        end
        gval_d = proc;
        cen_d = timer_on & (~ctl_q[tgc_pkg::BIT_GE] | proc);
    end

    // ======================================
    // single-pulse sequencer
    always_comb begin
        sp_d = sp_q;
        done_ev = 1'b0;
        // idle to armed on a go write, armed to pulse on a gate edge, then back
        unique case (sp_q)
            tgc_pkg::SP_IDLE: begin
                if (wr_ctl && pwdata[tgc_pkg::BIT_SPM] && pwdata[tgc_pkg::BIT_GO]) begin
                    sp_d = tgc_pkg::SP_ARMED;
                end
            end
            tgc_pkg::SP_ARMED: begin
                if (gated & ~gtd_prev_q) begin
                    sp_d = tgc_pkg::SP_PULSE;
                end
            end
            tgc_pkg::SP_PULSE: begin
                if (~gated) begin
                    sp_d = tgc_pkg::SP_IDLE;
                    done_ev = 1'b1;
                end
            end
            default: sp_d = tgc_pkg::SP_IDLE;
        endcase
        // leaving single-pulse mode drops the acquisition; a write is judged by
        // its own mode bit, so mode and go set together arm at once
        if (wr_ctl ? !pwdata[tgc_pkg::BIT_SPM] : !ctl_q[tgc_pkg::BIT_SPM]) begin
            sp_d = tgc_pkg::SP_IDLE;
        end
    end

    // ======================================
    // registers, interrupt and read data
    // primed keeps the first clock after reset from posting a false gate edge
    assign edge_ev = primed_q & proc & ~gval_q;
    always_comb begin
        ctl_d = ctl_q;
        if (wr_ctl) begin
            ctl_d = pwdata[7:0] & tgc_pkg::CTRL_WMASK;
        end
        imsk_d = wr_imsk ? pwdata[tgc_pkg::IRQ_W-1:0] : imsk_q;
        // write one to clear; a new event wins over the clear
        ist_d = ist_q & ~(wr_ist ? pwdata[tgc_pkg::IRQ_W-1:0] : '0);
        ist_d[tgc_pkg::IRQ_DONE] = ist_d[tgc_pkg::IRQ_DONE] | done_ev;
        ist_d[tgc_pkg::IRQ_EDGE] = ist_d[tgc_pkg::IRQ_EDGE] | edge_ev;
        // read data captured in setup, held through the access cycle
        rd_d = rd_q;
        if (setup) begin
            rd_d = 32'h0000_0000;
            if (paddr == tgc_pkg::OFF_GATE_CTRL) begin
                rd_d[7:0] = ctl_q;
                rd_d[tgc_pkg::BIT_GO] = go;
                rd_d[tgc_pkg::BIT_VAL] = gval_q;
            end else if (paddr == tgc_pkg::OFF_IRQ_STAT) begin
                rd_d[tgc_pkg::IRQ_W-1:0] = ist_q;
            end else if (paddr == tgc_pkg::OFF_IRQ_MASK) begin
                rd_d[tgc_pkg::IRQ_W-1:0] = imsk_q;
            end
        end
    end

    // all flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctl_q <= tgc_pkg::CTRL_RESET;
            ist_q <= tgc_pkg::IRQ_RESET;
            imsk_q <= tgc_pkg::IRQ_RESET;
            tff_q <= 1'b0;
            act_prev_q <= 1'b0;
            gtd_prev_q <= 1'b0;
            gval_q <= 1'b0;
            cen_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            sp_q <= tgc_pkg::SP_IDLE;
            primed_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            tff_q <= tff_d;
            act_prev_q <= act_prev_d;
            gtd_prev_q <= gtd_prev_d;
            gval_q <= gval_d;
            cen_q <= cen_d;
            rd_q <= rd_d;
            sp_q <= sp_d;
            primed_q <= primed_d;
        end
    end

    assign count_enable = cen_q;
    assign irq = |(ist_q & imsk_q);

    // ======================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // register bus
    ctl_reserved_a: assert property (ctl_q[tgc_pkg::BIT_GO:tgc_pkg::BIT_VAL] == 2'h0)
        else $error("control bits 3:2 stored nonzero");
    ctl_write_a: assert property (wr_ctl
        |=> ctl_q == ($past(pwdata[7:0]) & tgc_pkg::CTRL_WMASK))
        else $error("control write not stored");
    apb_ready_a: assert property (psel && penable |-> pready)
        else $error("access cycle without ready");
    rd_mask_a: assert property (psel && penable && !pwrite
        && paddr == tgc_pkg::OFF_IRQ_MASK |-> prdata[tgc_pkg::IRQ_W-1:0] == imsk_q)
        else $error("mask read data wrong");

    // gate routing
    tog_clear_a: assert property (!ctl_q[tgc_pkg::BIT_TM] |=> !tff_q)
        else $error("toggle flop not held clear");
    tog_flip_a: assert property (ctl_q[tgc_pkg::BIT_TM] && act && !act_prev_q
        |=> tff_q != $past(tff_q))
        else $error("toggle flop missed a rising edge");
    tog_route_a: assert property (ctl_q[tgc_pkg::BIT_TM] && !ctl_q[tgc_pkg::BIT_SPM]
        |=> gval_q == $past(tff_q))
        else $error("toggle flop not routed to gate");
    src_pin_a: assert property (plain_hi
        && ctl_q[tgc_pkg::BIT_SS_HI:tgc_pkg::BIT_SS_LO] == tgc_pkg::SRC_PIN
        |=> gval_q == $past(gate_pin))
        else $error("external pin not routed to gate");
    src_ovf_a: assert property (plain_hi
        && ctl_q[tgc_pkg::BIT_SS_HI:tgc_pkg::BIT_SS_LO] == tgc_pkg::SRC_OVF
        |=> gval_q == $past(other_overflow))
        else $error("overflow source not routed to gate");
    src_match_a: assert property (plain_hi
        && ctl_q[tgc_pkg::BIT_SS_HI:tgc_pkg::BIT_SS_LO] == tgc_pkg::SRC_MATCH
        |=> gval_q == $past(period_match))
        else $error("period match source not routed to gate");
    src_wdt_a: assert property (plain_hi
        && ctl_q[tgc_pkg::BIT_SS_HI:tgc_pkg::BIT_SS_LO] == tgc_pkg::SRC_WDT
        |=> gval_q == $past(watchdog_scaler))
        else $error("watchdog scaler source not routed to gate");
    pol_low_a: assert property (!ctl_q[tgc_pkg::BIT_POL] && !ctl_q[tgc_pkg::BIT_TM]
        && !ctl_q[tgc_pkg::BIT_SPM] |=> gval_q == !$past(src_raw))
        else $error("active-low gate level wrong");

    // single pulse
    sp_armed_a: assert property (ctl_q[tgc_pkg::BIT_SPM] && sp_q == tgc_pkg::SP_ARMED
        |=> !gval_q)
        else $error("gate open while armed");
    sp_inert_a: assert property (!ctl_q[tgc_pkg::BIT_SPM] |=> gval_q == $past(gated))
        else $error("pulse logic affected gate");
    sp_idle_a: assert property (!ctl_q[tgc_pkg::BIT_SPM]
        |-> sp_q == tgc_pkg::SP_IDLE)
        else $error("pulse sequencer busy outside single-pulse mode");
    go_arm_a: assert property (wr_ctl && pwdata[tgc_pkg::BIT_SPM] && pwdata[tgc_pkg::BIT_GO]
        && sp_q == tgc_pkg::SP_IDLE |=> go)
        else $error("go write did not arm the pulse");
    sp_wait_a: assert property (sp_q == tgc_pkg::SP_ARMED && !(gated && !gtd_prev_q)
        && ctl_q[tgc_pkg::BIT_SPM] && !wr_ctl |=> sp_q == tgc_pkg::SP_ARMED)
        else $error("armed pulse left without a gate edge");
    sp_start_a: assert property (sp_q == tgc_pkg::SP_ARMED && ctl_q[tgc_pkg::BIT_SPM]
        && gated && !gtd_prev_q && !wr_ctl
        |=> sp_q == tgc_pkg::SP_PULSE ##1 (gval_q == $past(gated)))
        else $error("armed pulse did not open gate");
    sp_done_a: assert property (sp_q == tgc_pkg::SP_PULSE && !gated
        |=> !go && ist_q[tgc_pkg::IRQ_DONE])
        else $error("go not cleared after pulse");
    spm_clr_a: assert property (wr_ctl && !pwdata[tgc_pkg::BIT_SPM] |=> !go)
        else $error("go survived clearing single-pulse mode");

    // timer count enable
    timer_off_a: assert property (!timer_on |=> !count_enable)
        else $error("counting while timer off");
    ungated_a: assert property (timer_on && !ctl_q[tgc_pkg::BIT_GE]
        |=> count_enable)
        else $error("ungated count enable low");
    cen_gate_a: assert property (timer_on && ctl_q[tgc_pkg::BIT_GE]
        |=> count_enable == $past(proc))
        else $error("gated count enable does not follow gate");

    // interrupt status
    done_set_a: assert property (done_ev |=> ist_q[tgc_pkg::IRQ_DONE])
        else $error("pulse done status not set");
    edge_set_a: assert property (primed_q && proc && !gval_q
        |=> ist_q[tgc_pkg::IRQ_EDGE])
        else $error("gate open status not set");
    w1c_a: assert property (wr_ist && pwdata[tgc_pkg::IRQ_DONE] && !done_ev
        |=> !ist_q[tgc_pkg::IRQ_DONE])
        else $error("done status not cleared by write one");
    sticky_a: assert property (ist_q[tgc_pkg::IRQ_DONE]
        && !(wr_ist && pwdata[tgc_pkg::IRQ_DONE]) |=> ist_q[tgc_pkg::IRQ_DONE])
        else $error("done status lost without a clear");
endmodule // tgc_gate_ctrl
`default_nettype wire

/* test/tgc_src_model.sv */
// model of the gate sources: pin, overflow, period match, watchdog scaler
`default_nettype none
module tgc_src_model (
    input wire logic clk,
    input wire logic [3:0] level,
    output logic gate_pin,
    output logic other_overflow,
    output logic period_match,
    output logic watchdog_scaler
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // sources move just after the clock edge, as synchronous levels
    always_ff @(posedge clk) begin
        {watchdog_scaler, period_match, other_overflow, gate_pin} <= level;
    end
endmodule // tgc_src_model
`default_nettype wire

/* test/tgc_gate_ctrl_tb_top.sv */
// self-checking bench for the timer gate control block
`default_nettype none
module tgc_gate_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CT = tgc_pkg::OFF_GATE_CTRL;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic timer_on = 1'b0, v, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, count_enable, irq, gp, ov, pm, ws;
    logic [3:0] level = 4'h0;
    int err_total = 0;
    int comparisons = 0;
    tgc_src_model SRC (.clk(clk), .level(level), .gate_pin(gp), .other_overflow(ov),
        .period_match(pm), .watchdog_scaler(ws));
    tgc_gate_ctrl DUT (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_on(timer_on), .gate_pin(gp), .other_overflow(ov),
        .period_match(pm), .watchdog_scaler(ws), .count_enable(count_enable), .irq(irq));
    // ==========================================
    // clock, 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end
    // counts, verdict and end of run
    task automatic close_out();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // compare one value
    task automatic check(input string w, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", w, e, g);
        end
    endtask
    // one apb transfer, bounded wait for pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                close_out();
            end
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic rdc(input string w, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(w, e, rd);
    endtask
    // source flop, sequencer and enable flop each add one clock
    task automatic cec(input logic e);
        idle(4);
        check("count enable", {31'h0, e}, {31'h0, count_enable});
    endtask
    // irq looked at one clock after the write that moves it
    task automatic irqc(input string w, input logic e);
        idle(1);
        check(w, {31'h0, e}, {31'h0, irq});
    endtask
    task automatic pulse();
        level <= 4'h1;
        idle(3);
        level <= 4'h0;
        idle(3);
    endtask
    // ==========================================
    // main sequence
    initial begin
        idle(3);
        rstn <= 1'b1;
        // value bit already shows the open active-low gate with sources low
        rdc("ctrl reset", CT, 32'h4);
        timer_on <= 1'b1;
        // every source, polarity and level; other sources opposite
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                for (int l = 0; l < 2; l++) begin
                    level <= (l == 1) ? (4'h1 << s) : ~(4'h1 << s);
                    apb(1'b1, CT, 32'h80 | (p << 6) | s);
                    v = (l == p);
                    cec(v);
                    rdc("ctrl value", CT, 32'h80 | (p << 6) | (v << 2) | s);
                end
            end
        end
        timer_on <= 1'b0;
        cec(1'b0);
        timer_on <= 1'b1;
        level <= 4'h0;
        apb(1'b1, CT, 32'h43);
        cec(1'b1);
        // toggle flop, then cleared by leaving toggle mode
        apb(1'b1, CT, 32'hE0);
        pulse();
        cec(1'b1);
        pulse();
        cec(1'b0);
        pulse();
        apb(1'b1, CT, 32'hC0);
        apb(1'b1, CT, 32'hE0);
        cec(1'b0);
        // single pulse with done interrupt
        apb(1'b1, tgc_pkg::OFF_IRQ_MASK, 32'h1);
        apb(1'b1, tgc_pkg::OFF_IRQ_STAT, 32'h3);
        apb(1'b1, CT, 32'hD8);
        rdc("ctrl armed", CT, 32'hD8);
        cec(1'b0);
        level <= 4'h1;
        cec(1'b1);
        level <= 4'h0;
        cec(1'b0);
        rdc("ctrl done", CT, 32'hD0);
        irqc("irq", 1'b1);
        level <= 4'h1;
        cec(1'b0);
        apb(1'b1, tgc_pkg::OFF_IRQ_MASK, 32'h0);
        irqc("irq masked", 1'b0);
        apb(1'b1, tgc_pkg::OFF_IRQ_MASK, 32'h1);
        irqc("irq unmasked", 1'b1);
        apb(1'b1, tgc_pkg::OFF_IRQ_STAT, 32'h1);
        irqc("irq cleared", 1'b0);
        // leaving single-pulse mode drops go and the pulse logic
        apb(1'b1, CT, 32'hD8);
        cec(1'b0);
        apb(1'b1, CT, 32'hC8);
        rdc("ctrl go dropped", CT, 32'hC4);
        cec(1'b1);
        // unmapped address
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped data", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, er});
        close_out();
    end
endmodule // tgc_gate_ctrl_tb_top
`default_nettype wire
